/* rtl/csi_pkg.sv */
// Purpose: Shared constants and types for the processor system interface request block.
// Assumes: One 100 MHz clock; AHB-Lite register slave with 32-bit data.
// Notes: Command field layouts are local choices; the block does not decode them beyond these bits.
package csi_pkg;
  localparam int ADDR_W = 32;
  localparam int NCMD_W = 9;
  localparam int LCMD_W = 5;
  localparam int BLOCK_WORDS = 8;
  localparam int MAX_READS = 4;
  // AHB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BUSERR = 8'h08;
  localparam logic [7:0] REG_PARERR = 8'h0C;
  // Control register fields and reset values
  localparam int CTRL_MULTI_BIT = 0;
  localparam int CTRL_PARCHK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status register fields
  localparam int STAT_LEGACY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PEND_LSB = 4;
  // Native command field bits
  localparam int NCMD_DATA_BIT = 8;
  localparam int NCMD_WRITE_BIT = 7;
  localparam int NCMD_LAST_BIT = 6;
  localparam int NCMD_ERR_BIT = 5;
  // Legacy command field bits
  localparam int LCMD_DATA_BIT = 4;
  localparam int LCMD_WRITE_BIT = 3;
  localparam int LCMD_LAST_BIT = 3;
  localparam int LCMD_ERR_BIT = 2;
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    SZ_BLOCK = 3'h0,
    SZ_DWORD = 3'h1,
    SZ_PDWORD = 3'h2,
    SZ_WORD = 3'h3,
    SZ_PWORD = 3'h4
  } csi_size_t;

  typedef enum logic [2:0] {
    EV_IFETCH_MISS = 3'h0,
    EV_LOAD_MISS = 3'h1,
    EV_STORE_MISS = 3'h2,
    EV_UNC_LOAD = 3'h3,
    EV_UNC_STORE = 3'h4,
    EV_CACHEOP_WB = 3'h5,
    EV_CACHEOP_FILL = 3'h6
  } csi_event_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_WDATA = 2'h2
  } csi_state_t;

  typedef struct packed {
    csi_event_t kind;
    csi_size_t size;
    logic [ADDR_W-1:0] addr;
  } csi_evt_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic err;
  } csi_rsp_t;

  function automatic logic [3:0] csi_beats(input csi_size_t sz);
    case (sz)
      SZ_BLOCK: csi_beats = 4'(BLOCK_WORDS);
      SZ_DWORD, SZ_PDWORD: csi_beats = 4'h2;
      default: csi_beats = 4'h1;
    endcase
  endfunction

  function automatic logic csi_is_write(input csi_event_t k);
    csi_is_write = (k == EV_UNC_STORE) || (k == EV_CACHEOP_WB);
  endfunction
endpackage

/* rtl/csi_requester.sv */
// Purpose: Processor-side request issuer for the multiplexed system interface.
// Assumes: All inputs synchronous to i_clk_sys; agent respects ordering and bus release.
// Notes: Each register and each pin output comes from a flop.
// Functional notes
// (R01) Compat select low at cold reset picks legacy protocol; high picks native protocol.
// (R02) Legacy mode forbids multiple split reads and bus parity generation or checking.
// (R03) Native mode: one shared bidirectional 32-bit address/data bus.
// (R04) Native mode: bidirectional 9-bit command bus accompanies each address or data.
// (R05) Legacy mode: command bus narrows to 5 bits, 32-bit data bus kept.
// (R06) Request is address plus command; writes send data beats, reads await response.
// (R07) All issued transactions are noncoherent; no snooping logic exists.
// (R08) Requests come from fetch misses, load/store misses, uncached accesses, cache ops.
// (R09) Transfer sizes: block, doubleword, partial doubleword, word, partial word.
// (R10) Configuration bit selects single-transaction or multiple-split-read sequencing.
// (R11) Single mode: after a read, wait for its response before any request.
// (R12) Single mode: write only when no read is outstanding.
// (R13) Split mode: several reads outstanding, writes may interleave.
// (R14) Agent must not split or overlap its own requests to the processor.
// (R15) Active-low read-ready input throttles read issue.
// (R16) Separate active-low write-ready input throttles write issue.
// (R17) Issue only if matching ready was asserted two cycles before issue cycle.
// (R18) Agent returns read responses in issue order.
// (R19) Read completes, no longer pending, only after final response word.
// (R20) Erroneous data identifier on response raises a bus error for that read.
// (R21) Each party floats shared buses when not driving; only one drives.
`timescale 1ns/100ps
module csi_requester
  import csi_pkg::*;
#(
  parameter int MAX_RD = MAX_READS
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // AHB-Lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System event side
  input wire logic i_evt_valid,
  input wire csi_evt_t i_evt,
  input wire logic [BLOCK_WORDS*32-1:0] i_evt_wdata,
  output logic o_evt_accept,
  output csi_rsp_t o_rsp,
  output logic o_rsp_valid,
  output logic o_bus_error,
  // System interface pins
  input wire logic i_compat_protocol_select_n,
  input wire logic [31:0] i_mux_addr_data_bus,
  output logic [31:0] o_mux_addr_data_bus,
  output logic o_mux_addr_data_bus_oe_n,
  input wire logic [NCMD_W-1:0] i_bus_command_field,
  output logic [NCMD_W-1:0] o_bus_command_field,
  output logic o_bus_command_field_oe_n,
  input wire logic [3:0] i_bus_parity,
  output logic [3:0] o_bus_parity,
  output logic o_valid_out_n,
  input wire logic i_valid_in_n,
  input wire logic i_read_accept_n,
  input wire logic i_write_accept_n
);
  localparam int PW = $clog2(MAX_RD + 1);
  localparam int IW = (MAX_RD > 1) ? $clog2(MAX_RD) : 1;

  logic rst_meta_n, rst_n;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // Mode strap is caught by a clock edge after release, never by the reset itself
  logic strap_done, legacy_compat_mode;
  logic next_strap_done, next_legacy;
  always_comb begin
    next_strap_done = 1'b1;
    next_legacy = strap_done ? legacy_compat_mode : ~i_compat_protocol_select_n; // [R01]
  end
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      legacy_compat_mode <= 1'b0;
    end else begin
      strap_done <= next_strap_done;
      legacy_compat_mode <= next_legacy;
    end
  end

  // Registers
  logic [1:0] ctrl;
  logic [15:0] buserr_cnt, parerr_cnt;
  logic ahb_wr_pend;
  logic [7:0] ahb_addr_q;
  logic [1:0] next_ctrl;
  logic [31:0] next_hrdata;
  logic next_wr_pend;
  logic [7:0] next_addr_q;
  logic multi_mode, par_mode;
  logic busy;
  logic [PW-1:0] pend_cnt;
  logic ahb_go;

  assign multi_mode = ctrl[CTRL_MULTI_BIT] & ~legacy_compat_mode; // [R10] [R02]
  assign par_mode = ~legacy_compat_mode; // [R02]
  assign ahb_go = hsel & hready & (htrans == HTRANS_NONSEQ);

  always_comb begin
    next_ctrl = ctrl;
    next_wr_pend = ahb_go & hwrite;
    next_addr_q = haddr[7:0];
    next_hrdata = hrdata;
    if (ahb_wr_pend && ahb_addr_q == REG_CTRL) begin
      next_ctrl = hwdata[1:0];
    end
    if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        REG_CTRL: next_hrdata = {30'h0, ctrl};
        REG_STATUS: next_hrdata = 32'({pend_cnt, 2'h0, busy, legacy_compat_mode});
        REG_BUSERR: next_hrdata = {16'h0, buserr_cnt};
        REG_PARERR: next_hrdata = {16'h0, parerr_cnt};
        default: next_hrdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      ahb_wr_pend <= 1'b0;
      ahb_addr_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ahb_wr_pend <= next_wr_pend;
      ahb_addr_q <= next_addr_q;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Issue sequencer and read tracking
  csi_state_t state, next_state;
  logic [31:0] wbuf [BLOCK_WORDS];
  logic [31:0] next_wbuf [BLOCK_WORDS];
  logic [3:0] beat, next_beat, nbeats, next_nbeats;
  csi_evt_t cur, next_cur;
  logic [PW-1:0] next_pend;
  csi_size_t szq [MAX_RD];
  csi_size_t next_szq [MAX_RD];
  logic [IW-1:0] qwr, qrd, next_qwr, next_qrd;
  logic [3:0] rbeat, next_rbeat;
  logic rerr, next_rerr;
  logic [31:0] next_bus;
  logic [NCMD_W-1:0] next_cmd;
  logic next_drive, next_accept, next_rsp_valid, next_bus_error;
  csi_rsp_t next_rsp;
  logic [15:0] next_buserr, next_parerr;
  logic can_rd, can_wr, take, is_wr, rsp_word, rsp_last, rsp_err, par_bad;
  logic [NCMD_W-1:0] cmd_word;

  assign busy = (state != ST_IDLE);
  // Single mode holds all issue while a read is pending; split mode caps the count
  // Ready is judged at the take edge, two cycles ahead of the issue cycle
  assign can_rd = ~i_read_accept_n & // [R15] [R17]
                  (multi_mode ? (pend_cnt < PW'(MAX_RD)) : (pend_cnt == '0)); // [R11] [R13]
  assign can_wr = ~i_write_accept_n & (multi_mode | (pend_cnt == '0)); // [R12] [R13] [R16] [R17]
  assign is_wr = csi_is_write(i_evt.kind); // [R08]
  // Response words only arrive while the agent owns the bus
  assign rsp_word = ~i_valid_in_n & o_mux_addr_data_bus_oe_n &
                    (legacy_compat_mode ? i_bus_command_field[LCMD_DATA_BIT] : i_bus_command_field[NCMD_DATA_BIT]);
  assign rsp_err = legacy_compat_mode ? i_bus_command_field[LCMD_ERR_BIT] : i_bus_command_field[NCMD_ERR_BIT];
  assign rsp_last = (rbeat + 4'h1) >= csi_beats(szq[qrd]);
  assign par_bad = ctrl[CTRL_PARCHK_BIT] & par_mode & (pend_cnt != '0) & rsp_word &
                   (i_bus_parity != {^i_mux_addr_data_bus[31:24], ^i_mux_addr_data_bus[23:16],
                                     ^i_mux_addr_data_bus[15:8], ^i_mux_addr_data_bus[7:0]}); // [R02]
  assign take = (state == ST_IDLE) & i_evt_valid & ~o_evt_accept & i_valid_in_n & (is_wr ? can_wr : can_rd);

  // Noncoherent by construction: nothing snoops the bus [R07]
  always_comb begin
    cmd_word = '0;
    if (legacy_compat_mode) begin
      cmd_word[LCMD_WRITE_BIT] = csi_is_write(cur.kind);
      cmd_word[2:0] = cur.size; // [R05] [R09]
    end else begin
      cmd_word[NCMD_WRITE_BIT] = csi_is_write(cur.kind);
      cmd_word[2:0] = cur.size; // [R04] [R09]
    end
  end

  always_comb begin
    next_state = state;
    next_wbuf = wbuf;
    next_beat = beat;
    next_nbeats = nbeats;
    next_cur = cur;
    next_pend = pend_cnt;
    next_szq = szq;
    next_qwr = qwr;
    next_qrd = qrd;
    next_rbeat = rbeat;
    next_rerr = rerr;
    next_bus = o_mux_addr_data_bus;
    next_cmd = '0;
    next_drive = 1'b0;
    next_accept = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp = o_rsp;
    next_bus_error = 1'b0;
    next_buserr = buserr_cnt;
    next_parerr = par_bad ? parerr_cnt + 16'h1 : parerr_cnt;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_cur = i_evt;
          next_nbeats = csi_beats(i_evt.size);
          for (int i = 0; i < BLOCK_WORDS; i++) begin
            next_wbuf[i] = i_evt_wdata[i*32 +: 32];
          end
          next_accept = 1'b1;
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // Issue cycle: address with its command on the shared buses
        next_bus = cur.addr; // [R03] [R06]
        next_cmd = cmd_word;
        next_drive = 1'b1;
        next_beat = 4'h0;
        next_state = csi_is_write(cur.kind) ? ST_WDATA : ST_IDLE; // [R06]
      end
      ST_WDATA: begin
        next_bus = wbuf[beat[2:0]]; // [R06]
        next_cmd[legacy_compat_mode ? LCMD_DATA_BIT : NCMD_DATA_BIT] = 1'b1;
        next_cmd[legacy_compat_mode ? LCMD_LAST_BIT : NCMD_LAST_BIT] = (beat + 4'h1) == nbeats;
        next_drive = 1'b1;
        next_beat = beat + 4'h1;
        if ((beat + 4'h1) == nbeats) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A read becomes pending on its issue cycle
    if (state == ST_ADDR && !csi_is_write(cur.kind)) begin
      next_szq[qwr] = cur.size;
      next_qwr = (qwr == IW'(MAX_RD - 1)) ? '0 : qwr + IW'(1);
      next_pend = next_pend + PW'(1);
    end
    // Responses taken in issue order, one size record per pending read [R18]
    if (rsp_word && pend_cnt != '0) begin
      next_rsp_valid = 1'b1;
      next_rsp.data = i_mux_addr_data_bus;
      next_rsp.last = rsp_last;
      next_rsp.err = rsp_err;
      next_rerr = rerr | rsp_err;
      next_rbeat = rbeat + 4'h1;
      if (rsp_last) begin
        next_rbeat = 4'h0;
        next_rerr = 1'b0;
        next_qrd = (qrd == IW'(MAX_RD - 1)) ? '0 : qrd + IW'(1);
        next_pend = next_pend - PW'(1); // [R19]
        if (rerr || rsp_err) begin
          next_bus_error = 1'b1; // [R20]
          next_buserr = buserr_cnt + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      for (int i = 0; i < BLOCK_WORDS; i++) begin
        wbuf[i] <= 32'h0;
      end
      for (int i = 0; i < MAX_RD; i++) begin
        szq[i] <= SZ_BLOCK;
      end
      beat <= 4'h0;
      nbeats <= 4'h0;
      cur <= '0;
      pend_cnt <= '0;
      qwr <= '0;
      qrd <= '0;
      rbeat <= 4'h0;
      rerr <= 1'b0;
      buserr_cnt <= 16'h0;
      parerr_cnt <= 16'h0;
      o_mux_addr_data_bus <= 32'h0;
      o_mux_addr_data_bus_oe_n <= 1'b1;
      o_bus_command_field <= '0;
      o_bus_command_field_oe_n <= 1'b1;
      o_bus_parity <= 4'h0;
      o_valid_out_n <= 1'b1;
      o_evt_accept <= 1'b0;
      o_rsp <= '0;
      o_rsp_valid <= 1'b0;
      o_bus_error <= 1'b0;
    end else begin
      state <= next_state;
      wbuf <= next_wbuf;
      szq <= next_szq;
      beat <= next_beat;
      nbeats <= next_nbeats;
      cur <= next_cur;
      pend_cnt <= next_pend;
      qwr <= next_qwr;
      qrd <= next_qrd;
      rbeat <= next_rbeat;
      rerr <= next_rerr;
      buserr_cnt <= next_buserr;
      parerr_cnt <= next_parerr;
      o_mux_addr_data_bus <= next_bus;
      // Released whenever not issuing, so the agent may drive [R21]
      o_mux_addr_data_bus_oe_n <= ~next_drive; // [R21]
      o_bus_command_field <= next_cmd;
      o_bus_command_field_oe_n <= ~next_drive; // [R21]
      // Parity only in native mode [R02]
      o_bus_parity <= (next_drive && par_mode) ?
                      {^next_bus[31:24], ^next_bus[23:16], ^next_bus[15:8], ^next_bus[7:0]} : 4'h0;
      o_valid_out_n <= ~next_drive;
      o_evt_accept <= next_accept;
      o_rsp <= next_rsp;
      o_rsp_valid <= next_rsp_valid;
      o_bus_error <= next_bus_error;
    end
  end
endmodule

/* tb/csi_requester_monitor.sv */
// Purpose: Pin-level checks on the request block.
// Assumes: Strap only changes while reset is low; CTRL is followed from AHB writes.
// Notes: Sees top ports only; attached by bind.
`timescale 1ns/100ps
module csi_requester_monitor
  import csi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic o_evt_accept,
  input wire csi_rsp_t o_rsp,
  input wire logic o_rsp_valid,
  input wire logic o_bus_error,
  input wire logic i_compat_protocol_select_n,
  input wire logic [31:0] i_mux_addr_data_bus,
  input wire logic [31:0] o_mux_addr_data_bus,
  input wire logic o_mux_addr_data_bus_oe_n,
  input wire logic [8:0] i_bus_command_field,
  input wire logic [8:0] o_bus_command_field,
  input wire logic o_bus_command_field_oe_n,
  input wire logic [3:0] o_bus_parity,
  input wire logic o_valid_out_n,
  input wire logic i_valid_in_n,
  input wire logic i_read_accept_n,
  input wire logic i_write_accept_n
);
  logic ctl_ph, multi, rd_open, next_ctl_ph, next_multi, next_rd_open;
  wire legacy = !i_compat_protocol_select_n;
  wire [8:0] c = o_bus_command_field;
  wire adr = !o_valid_out_n && !c[8] && !c[4];
  wire wr = legacy ? c[3] : c[7];
  wire rin = !i_valid_in_n && o_mux_addr_data_bus_oe_n && (legacy ? i_bus_command_field[4] : i_bus_command_field[8]);
  wire rerr = legacy ? i_bus_command_field[2] : i_bus_command_field[5];
  always_comb begin
    next_ctl_ph = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == REG_CTRL;
    next_multi = ctl_ph ? hwdata[CTRL_MULTI_BIT] : multi;
    next_rd_open = (adr && !wr) || (rd_open && !(o_rsp_valid && o_rsp.last));
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) {ctl_ph, multi, rd_open} <= 3'h0;
    else {ctl_ph, multi, rd_open} <= {next_ctl_ph, next_multi, next_rd_open};
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  sequence s_rd_issue; adr && !wr; endsequence
  sequence s_wr_issue; adr && wr; endsequence
  sequence s_beat; !o_valid_out_n && (legacy ? c[4] : c[8]); endsequence
  AST_RD_READY: assert property (s_rd_issue |-> $past(i_read_accept_n, 2) == 1'b0)
    else $error("read issued without read ready two cycles before");
  AST_WR_READY: assert property (s_wr_issue |-> $past(i_write_accept_n, 2) == 1'b0)
    else $error("write issued without write ready two cycles before");
  AST_WR_DATA: assert property (s_wr_issue |=> s_beat)
    else $error("write address not followed by a data beat");
  AST_ACCEPT_ISSUE: assert property (o_evt_accept |=> adr)
    else $error("accepted event not issued next cycle");
  AST_SINGLE: assert property (!(adr && rd_open && (legacy || !multi)))
    else $error("request issued while a read is pending in single mode");
  AST_DRIVE: assert property (o_mux_addr_data_bus_oe_n == o_valid_out_n && o_bus_command_field_oe_n == o_valid_out_n)
    else $error("bus enables differ from valid cycle");
  AST_RSP: assert property (rin |=> o_rsp_valid && o_rsp.err == $past(rerr) &&
    o_rsp.data == $past(i_mux_addr_data_bus))
    else $error("response word not passed on");
  AST_BUSERR: assert property (o_bus_error |-> o_rsp_valid && o_rsp.last)
    else $error("bus error outside read completion");
  AST_LEGACY_PAR: assert property (legacy && !o_valid_out_n |-> o_bus_parity == 4'h0 && c[8:5] == 4'h0)
    else $error("parity or wide command in legacy mode");
  AST_NAT_PAR: assert property (!legacy && !o_valid_out_n |->
    o_bus_parity == {^o_mux_addr_data_bus[31:24], ^o_mux_addr_data_bus[23:16], ^o_mux_addr_data_bus[15:8],
    ^o_mux_addr_data_bus[7:0]})
    else $error("bus parity wrong in native mode");
endmodule
bind csi_requester csi_requester_monitor i_csi_requester_monitor (.*);

/* tb/csi_agent_model.sv */
// Purpose: External agent answering reads in issue order.
// Assumes: Bench sets ready hold, slow answer and error marking.
// Notes: Released lines toggle so a stale value never passes.
`timescale 1ns/100ps
module csi_agent_model (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_legacy,
  input wire logic [31:0] i_bus,
  input wire logic [8:0] i_cmd,
  input wire logic i_oe_n,
  input wire logic i_valid_n,
  input wire logic i_hold,
  input wire logic i_slow,
  input wire logic i_err,
  output logic [31:0] o_bus,
  output logic [8:0] o_cmd,
  output logic o_valid_n,
  output logic o_rd_acc_n,
  output logic o_wr_acc_n
);
  logic [31:0] qa[$];
  int qn[$];
  int beat;
  int gap;
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qa.delete();
      qn.delete();
      beat = 0;
      gap = 0;
      o_bus <= 32'h0;
      o_cmd <= 9'h0;
      o_valid_n <= 1'b1;
      o_rd_acc_n <= 1'b1;
      o_wr_acc_n <= 1'b1;
    end else begin
      o_rd_acc_n <= i_hold;
      o_wr_acc_n <= i_hold;
      if (!i_valid_n && !i_cmd[8] && !i_cmd[4] && !(i_legacy ? i_cmd[3] : i_cmd[7])) begin
        qa.push_back(i_bus);
        qn.push_back(i_cmd[2:0] == 3'h0 ? 8 : (i_cmd[2:0] < 3'h3 ? 2 : 1));
        gap = i_slow ? 16 : 2;
      end
      if (gap > 0) gap--;
      if (gap == 0 && qn.size() > 0 && i_oe_n) begin
        o_bus <= qa[0] + beat;
        o_cmd <= i_legacy ? {4'h0, 1'b1, 1'b0, i_err, 2'h0} : {1'b1, 2'h0, i_err, 5'h0};
        o_valid_n <= 1'b0;
        beat++;
        if (beat == qn[0]) begin
          void'(qa.pop_front());
          void'(qn.pop_front());
          beat = 0;
        end
      end else begin
        o_bus <= ~o_bus;
        o_cmd <= ~o_cmd;
        o_valid_n <= 1'b1;
      end
    end
  end
endmodule

/* tb/csi_requester_tb.sv */
// Purpose: Directed bench for the request block.
// Assumes: Zero-wait AHB slave; agent model on the far side.
// Notes: Counters are read a few cycles after traffic settles.
`timescale 1ns/100ps
module csi_requester_tb;
  import csi_pkg::*;
  logic clk, rst_n = 1'b0, strap = 1'b1, hwrite = 1'b0, evt_valid = 1'b0, hold = 1'b0, slow = 1'b0, err = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dev_bus, ag_bus, q;
  logic [1:0] htrans = 2'h0;
  logic [8:0] dev_cmd, ag_cmd;
  logic [255:0] wdata = 256'h0;
  logic hreadyout, evt_accept, rsp_valid, bus_error, dev_oe_n, cmd_oe_n, valid_out_n, ag_valid_n, rd_acc_n, wr_acc_n;
  csi_evt_t evt = '0;
  csi_rsp_t rsp;
  logic [40:0] seen[$];
  int n_fail, n_checks, n_rsp, n_berr, n_acc, r0, e;
  wire [31:0] bus_w = dev_oe_n ? ag_bus : dev_bus;
  wire [8:0] cmd_w = cmd_oe_n ? ag_cmd : dev_cmd;
  csi_requester i_csi_requester (.i_clk_sys(clk), .i_reset_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .i_evt_valid(evt_valid), .i_evt(evt), .i_evt_wdata(wdata), .o_evt_accept(evt_accept), .o_rsp(rsp),
    .o_rsp_valid(rsp_valid), .o_bus_error(bus_error), .i_compat_protocol_select_n(strap), .i_mux_addr_data_bus(bus_w),
    .o_mux_addr_data_bus(dev_bus), .o_mux_addr_data_bus_oe_n(dev_oe_n), .i_bus_command_field(cmd_w),
    .o_bus_command_field(dev_cmd), .o_bus_command_field_oe_n(cmd_oe_n), .i_bus_parity(4'h0), .o_bus_parity(),
    .o_valid_out_n(valid_out_n), .i_valid_in_n(ag_valid_n), .i_read_accept_n(rd_acc_n), .i_write_accept_n(wr_acc_n));
  csi_agent_model i_csi_agent_model (.i_clk_sys(clk), .i_reset_n(rst_n), .i_legacy(!strap), .i_bus(dev_bus),
    .i_cmd(dev_cmd), .i_oe_n(dev_oe_n), .i_valid_n(valid_out_n), .i_hold(hold), .i_slow(slow), .i_err(err),
    .o_bus(ag_bus), .o_cmd(ag_cmd), .o_valid_n(ag_valid_n), .o_rd_acc_n(rd_acc_n), .o_wr_acc_n(wr_acc_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_rsp += int'(rsp_valid === 1'b1);
    n_berr += int'(bus_error === 1'b1);
    n_acc += int'(evt_accept === 1'b1);
    if (valid_out_n === 1'b0) seen.push_back({dev_cmd, dev_bus});
  end
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(inout int k);
    k++;
    if (k > 300) begin
      chk(32'h0, 32'h1);
      complete_run();
    end
  endtask
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int k = 0;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin @(posedge clk); guard(k); end
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin @(posedge clk); guard(k); end
    rd = hrdata;
  endtask
  task automatic evt_go(input csi_event_t kd, input csi_size_t sz, input logic [31:0] a);
    int k = 0;
    evt_valid <= 1'b1;
    evt <= '{kd, sz, a};
    @(posedge clk);
    while (evt_accept !== 1'b1) begin @(posedge clk); guard(k); end
    evt_valid <= 1'b0;
    @(posedge clk);
  endtask
  function automatic int nb(input int s);
    return s == 0 ? 8 : (s < 3 ? 2 : 1);
  endfunction
  initial begin
    do_reset(1'b1);
    ahb(1'b0, REG_CTRL, 32'h0, q); chk(q, 32'h0);
    ahb(1'b0, REG_STATUS, 32'h0, q); chk(32'(q[STAT_LEGACY_BIT]), 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    ahb(1'b0, 8'h40, 32'h0, q); chk(q, 32'h0);
    wdata <= {224'h0, 32'hA5C3_0F11};
    seen.delete();
    evt_go(EV_UNC_STORE, SZ_WORD, 32'h1000);
    repeat (3) @(posedge clk);
    chk(seen[0][31:0], 32'h1000);
    chk(32'(seen[0][40:32] & 9'h087), 32'h083);
    chk(seen[1][31:0], 32'hA5C3_0F11);
    chk(32'(seen[1][40:32] & 9'h140), 32'h140);
    r0 = n_rsp;
    e = 0;
    for (int i = 0; i < 7; i++) begin
      if (i != 4 && i != 5) e += nb(i % 5);
      evt_go(csi_event_t'(i), csi_size_t'(i % 5), 32'h100 * i);
    end
    repeat (20) @(posedge clk);
    chk(n_rsp - r0, e);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    evt_valid <= 1'b1;
    evt <= '{EV_LOAD_MISS, SZ_WORD, 32'h3000};
    r0 = n_acc;
    repeat (20) @(posedge clk);
    chk(n_acc - r0, 0);
    hold <= 1'b0;
    evt_go(EV_LOAD_MISS, SZ_WORD, 32'h3000);
    repeat (10) @(posedge clk);
    err <= 1'b1;
    r0 = n_berr;
    evt_go(EV_UNC_LOAD, SZ_DWORD, 32'h2000);
    repeat (10) @(posedge clk);
    chk(n_berr - r0, 1);
    err <= 1'b0;
    ahb(1'b0, REG_BUSERR, 32'h0, q); chk(q, 32'h1);
    slow <= 1'b1;
    evt_go(EV_UNC_LOAD, SZ_WORD, 32'h4000);
    r0 = n_rsp;
    evt_go(EV_UNC_STORE, SZ_WORD, 32'h4100);
    chk(32'(n_rsp != r0), 32'h1);
    repeat (10) @(posedge clk);
    ahb(1'b1, REG_CTRL, 32'h1, q);
    r0 = n_rsp;
    evt_go(EV_LOAD_MISS, SZ_WORD, 32'h5000);
    evt_go(EV_UNC_LOAD, SZ_WORD, 32'h5100);
    evt_go(EV_UNC_STORE, SZ_WORD, 32'h5200);
    chk(n_rsp - r0, 0);
    repeat (30) @(posedge clk);
    chk(n_rsp - r0, 2);
    ahb(1'b1, REG_CTRL, 32'h2, q);
    evt_go(EV_UNC_LOAD, SZ_WORD, 32'h1);
    repeat (25) @(posedge clk);
    ahb(1'b0, REG_PARERR, 32'h0, q); chk(q, 32'h1);
    do_reset(1'b0);
    ahb(1'b0, REG_STATUS, 32'h0, q); chk(32'(q[STAT_LEGACY_BIT]), 32'h1);
    ahb(1'b1, REG_CTRL, 32'h1, q);
    r0 = n_rsp;
    evt_go(EV_UNC_LOAD, SZ_WORD, 32'h6000);
    evt_go(EV_UNC_STORE, SZ_WORD, 32'h6100);
    repeat (4) @(posedge clk);
    chk(n_rsp - r0, 1);
    chk(seen[seen.size()-1][31:0], 32'hA5C3_0F11);
    chk(32'(seen[seen.size()-1][40:36]), 32'h1);
    complete_run();
  end
endmodule
